// >>> logic/lse_pkg.sv
// Purpose: Shared constants and types for the line sense error logic
// Assumes: 100 MHz system clock
// Notes:   Sense byte bit 0 is the most significant bit of the returned byte
package lse_pkg;

  // ----------------------------------------
  // Commands
  // ----------------------------------------
  typedef enum logic [3:0] {
    LSE_CMD_WRITE, LSE_CMD_READ, LSE_CMD_POLL, LSE_CMD_SEARCH,
    LSE_CMD_PREPARE, LSE_CMD_ADD_PREP, LSE_CMD_ENABLE, LSE_CMD_DISABLE,
    LSE_CMD_DIAL, LSE_CMD_WRAP, LSE_CMD_BREAK, LSE_CMD_SENSE,
    LSE_CMD_INHIBIT, LSE_CMD_SET_MODE, LSE_CMD_NOP
  } lse_cmd_t;

  // ----------------------------------------
  // Sense field bit positions (Verilog index, bit 7 is MSB of byte)
  // ----------------------------------------
  localparam int LSE_SB_INTV = 6;
  localparam int LSE_SB_BUSP = 5;
  localparam int LSE_SB_EQCK = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint LSE_CLK_HZ      = 100_000_000;
  localparam longint LSE_TX_TMO_S    = 28;
  localparam longint LSE_RX_TMO_S    = 1;
  localparam longint LSE_TX_TMO_CYC  = LSE_TX_TMO_S * LSE_CLK_HZ;
  localparam longint LSE_RX_TMO_CYC  = LSE_RX_TMO_S * LSE_CLK_HZ;
  localparam int     LSE_TMO_W       = 32;
  localparam logic [7:0] LSE_SENSE_RST = 8'h00;

  // ----------------------------------------
  // Command strobe from the channel
  // ----------------------------------------
  typedef struct packed {
    logic     valid;
    lse_cmd_t cmd;
    logic [7:0] byte_val;
    logic     parity;
  } lse_cmd_in_t;

  // ----------------------------------------
  // Modem and adapter status
  // ----------------------------------------
  typedef struct packed {
    logic power_on;
    logic off_hook;
    logic data_mode;
    logic attached;
    logic line_enabled;
    logic tx_oper;
    logic rx_oper;
    logic acu_power_on;
    logic acu_attached;
  } lse_modem_t;

  typedef enum logic [1:0] {LSE_IDLE, LSE_WAIT_TX, LSE_WAIT_RX} lse_state_t;

  typedef struct packed {
    lse_state_t       state;
    logic [LSE_TMO_W-1:0] cnt;
    logic [LSE_TMO_W-1:0] limit;
    logic             active;
    logic [7:0]       sense;
    logic [7:0]       sense_out;
    logic             sense_vld;
  } lse_regs_t;

endpackage

// >>> logic/lse_line_sense.sv
// Purpose: Error sense bits for one communications line
// Assumes: Inputs synchronous to i_sys_clk; transmit and receive timeouts are parameters, prepare timeout is an input
// Notes:   Sense byte held until the next non-sense command to the line
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Sync write or poll sets intervention required if transmit operational is not reached in 28 s.
// - Sync read, search or address prepare sets intervention if receive operational misses 1 s.
// - Sync prepare sets intervention if receive operational misses the terminal-chosen timeout.
// - Sync write, poll, read, search and prepare commands report intervention for modem power off, on hook, no data mode, absent or disabled.
// - Dial reports intervention when the calling unit is off or absent.
// - Bad odd parity on bus-out data during write, dial, wrap or break sets bus-out parity.
// - Bad parity on the command byte of any command sets bus-out parity.
// - A new command while one is still active sets equipment check.
// - Base check or storage parity check sets equipment check for any command.
// - Enable that leaves the enable latch clear flags equipment check.
// - Disable that leaves the enable latch set flags equipment check.
// - Dial flags equipment check if the call request latch fails to set or clear.
// - Sense returns one byte from the stored sense field of the line.
module lse_line_sense
  import lse_pkg::*;
#(
  parameter longint TX_TMO_CYC = LSE_TX_TMO_CYC,
  parameter longint RX_TMO_CYC = LSE_RX_TMO_CYC
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Channel side
  input  wire lse_cmd_in_t i_cmd,
  input  wire logic        i_data_svc,
  input  wire logic [7:0]  i_bus_out,
  input  wire logic        i_bus_out_par,
  input  wire logic        i_cmd_end,
  // Line configuration and status
  input  wire logic        i_sync_terminal_mode,
  input  wire lse_modem_t  i_modem,
  input  wire logic [LSE_TMO_W-1:0] i_prep_tmo_cyc,
  // Internal checks
  input  wire logic        i_base_check,
  input  wire logic        i_store_par_check,
  input  wire logic        i_xfer_chk_vld,
  input  wire logic [7:0]  i_serializer,
  input  wire logic [7:0]  i_tx_latch,
  input  wire logic        i_latch_chk_vld,
  input  wire logic        i_enable_latch,
  input  wire logic        i_call_req_latch,
  input  wire logic        i_call_req_expect,
  // Sense answer and command status
  output logic [7:0]       o_sense_byte,
  output logic             o_sense_vld,
  output logic [7:0]       o_sense_field,
  output logic             o_cmd_active
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  lse_regs_t  r_ff;
  lse_regs_t  nxt_r;
  lse_cmd_t   cur_cmd_ff;
  lse_cmd_t   nxt_cur_cmd;
  logic       modem_bad;
  logic       new_cmd;

  assign modem_bad = !i_modem.power_on || !i_modem.off_hook || !i_modem.data_mode ||
                     !i_modem.attached || !i_modem.line_enabled;
  assign new_cmd   = i_cmd.valid && (i_cmd.cmd != LSE_CMD_SENSE);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_r       = r_ff;
    nxt_cur_cmd = cur_cmd_ff;
    nxt_r.sense_vld = 1'b0;
    // ----------------------------------------
    // Command acceptance
    // ----------------------------------------
    if (i_cmd.valid) begin
      if (i_cmd.cmd == LSE_CMD_SENSE) begin
        nxt_r.sense_out = r_ff.sense;
        nxt_r.sense_vld = 1'b1;
      end else begin
        // Clearing here means a sense after this command sees only its own errors
        nxt_r.sense  = LSE_SENSE_RST;
        nxt_r.active = 1'b1;
        nxt_cur_cmd  = i_cmd.cmd;
        nxt_r.state  = LSE_IDLE;
        nxt_r.cnt    = '0;
        if (r_ff.active) begin
          nxt_r.sense[LSE_SB_EQCK] = 1'b1;
        end
        if (i_sync_terminal_mode) begin
          case (i_cmd.cmd)
            LSE_CMD_WRITE, LSE_CMD_POLL: begin
              nxt_r.state = LSE_WAIT_TX;
              nxt_r.limit = TX_TMO_CYC[LSE_TMO_W-1:0];
            end
            LSE_CMD_READ, LSE_CMD_SEARCH, LSE_CMD_ADD_PREP: begin
              nxt_r.state = LSE_WAIT_RX;
              nxt_r.limit = RX_TMO_CYC[LSE_TMO_W-1:0];
            end
            LSE_CMD_PREPARE: begin
              nxt_r.state = LSE_WAIT_RX;
              nxt_r.limit = i_prep_tmo_cyc;
            end
            default: nxt_r.state = LSE_IDLE;
          endcase
          if (modem_bad && i_cmd.cmd inside {LSE_CMD_WRITE, LSE_CMD_POLL, LSE_CMD_READ,
              LSE_CMD_SEARCH, LSE_CMD_ADD_PREP, LSE_CMD_PREPARE}) begin
            nxt_r.sense[LSE_SB_INTV] = 1'b1;
          end
        end
        if (i_cmd.cmd == LSE_CMD_DIAL &&
            (!i_modem.acu_power_on || !i_modem.acu_attached)) begin
          nxt_r.sense[LSE_SB_INTV] = 1'b1;
        end
      end
      if (^{i_cmd.byte_val, i_cmd.parity} != 1'b1) begin
        nxt_r.sense[LSE_SB_BUSP] = 1'b1;
      end
    end
    // ----------------------------------------
    // Modem readiness timeouts
    // ----------------------------------------
    // A new command restarts the timer, so the old wait must not overwrite it
    if (!new_cmd) begin
      case (r_ff.state)
        LSE_WAIT_TX, LSE_WAIT_RX: begin
          if ((r_ff.state == LSE_WAIT_TX) ? i_modem.tx_oper : i_modem.rx_oper) begin
            nxt_r.state = LSE_IDLE;
          end else if (r_ff.cnt >= r_ff.limit - 1'b1) begin
            nxt_r.sense[LSE_SB_INTV] = 1'b1;
            nxt_r.state = LSE_IDLE;
          end else begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
          end
        end
        default: ;
      endcase
    end
    // ----------------------------------------
    // Checks while a command is active
    // ----------------------------------------
    // Checks are skipped in the cycle of a new command, which has just cleared the field
    if (r_ff.active && !new_cmd) begin
      if (i_data_svc && (^{i_bus_out, i_bus_out_par} != 1'b1) &&
          cur_cmd_ff inside {LSE_CMD_WRITE, LSE_CMD_DIAL, LSE_CMD_WRAP, LSE_CMD_BREAK}) begin
        nxt_r.sense[LSE_SB_BUSP] = 1'b1;
      end
      if (!i_sync_terminal_mode && i_xfer_chk_vld && (i_serializer != i_tx_latch) &&
          cur_cmd_ff inside {LSE_CMD_WRITE, LSE_CMD_POLL, LSE_CMD_WRAP, LSE_CMD_BREAK}) begin
        nxt_r.sense[LSE_SB_EQCK] = 1'b1;
      end
      if (i_latch_chk_vld) begin
        case (cur_cmd_ff)
          LSE_CMD_ENABLE: begin
            if (!i_enable_latch) begin
              nxt_r.sense[LSE_SB_EQCK] = 1'b1;
            end
          end
          LSE_CMD_DISABLE: begin
            if (i_enable_latch) begin
              nxt_r.sense[LSE_SB_EQCK] = 1'b1;
            end
          end
          LSE_CMD_DIAL: begin
            if (i_call_req_latch != i_call_req_expect) begin
              nxt_r.sense[LSE_SB_EQCK] = 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (i_cmd_end) begin
        nxt_r.active = 1'b0;
        nxt_r.state  = LSE_IDLE;
      end
    end
    // ----------------------------------------
    // Internal checks
    // ----------------------------------------
    // Internal checks win over a same-cycle clear
    if (i_base_check || i_store_par_check) begin
      nxt_r.sense[LSE_SB_EQCK] = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_ff       <= '0;
      cur_cmd_ff <= LSE_CMD_NOP;
    end else begin
      r_ff       <= nxt_r;
      cur_cmd_ff <= nxt_cur_cmd;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_sense_byte  = r_ff.sense_out;
  assign o_sense_vld   = r_ff.sense_vld;
  assign o_sense_field = r_ff.sense;
  assign o_cmd_active  = r_ff.active;

endmodule

`default_nettype wire

// >>> testbench/lse_props.sv
// Purpose: Checker for the line sense error logic
// Assumes: Sees only the ports of lse_line_sense
// Notes:   Field bits 6, 5, 4 are intervention, bus-out parity, equipment check
`timescale 1ns/1ps
`default_nettype none
module lse_props
  import lse_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire lse_cmd_in_t i_cmd,
  input wire logic        i_data_svc,
  input wire logic [7:0]  i_bus_out,
  input wire logic        i_bus_out_par,
  input wire logic        i_sync_terminal_mode,
  input wire lse_modem_t  i_modem,
  input wire logic        i_base_check,
  input wire logic        i_store_par_check,
  input wire logic [7:0]  o_sense_byte,
  input wire logic        o_sense_vld,
  input wire logic [7:0]  o_sense_field,
  input wire logic        o_cmd_active
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic nc;
  logic pok;
  lse_cmd_t last_cmd;
  always_ff @(posedge i_sys_clk) begin
    if (nc) last_cmd <= i_cmd.cmd;
  end
  assign nc  = i_cmd.valid && i_cmd.cmd != LSE_CMD_SENSE;
  assign pok = ^{i_cmd.byte_val, i_cmd.parity};
  a_sense_answer: assert property (i_cmd.valid && i_cmd.cmd == LSE_CMD_SENSE && pok |=>
    o_sense_vld && o_sense_byte == $past(o_sense_field)) else $error("sense answer wrong");
  a_sense_cause: assert property (o_sense_vld |->
    $past(i_cmd.valid && i_cmd.cmd == LSE_CMD_SENSE)) else $error("stray sense valid");
  a_cmd_parity: assert property (i_cmd.valid && !pok |=> o_sense_field[5])
    else $error("command parity not flagged");
  a_data_parity: assert property (o_cmd_active && !i_cmd.valid && i_data_svc
    && last_cmd inside {LSE_CMD_WRITE, LSE_CMD_DIAL, LSE_CMD_WRAP, LSE_CMD_BREAK}
    && !(^{i_bus_out, i_bus_out_par}) |=> o_sense_field[5]) else $error("data parity missed");
  a_busy_cmd: assert property (nc && o_cmd_active |=> o_sense_field[4])
    else $error("busy command not flagged");
  a_base_check: assert property (i_base_check || i_store_par_check |=> o_sense_field[4])
    else $error("base check not flagged");
  a_modem_down: assert property (nc && pok && i_sync_terminal_mode && !i_modem.power_on
    && i_cmd.cmd == LSE_CMD_WRITE |=> o_sense_field[6]) else $error("modem down missed");
  a_field_clear: assert property (nc && pok && !o_cmd_active && !i_base_check
    && !i_store_par_check |=> o_sense_field[5:4] == 2'b00) else $error("field not cleared");
  a_field_hold: assert property (!nc |=>
    (o_sense_field & $past(o_sense_field)) == $past(o_sense_field)) else $error("bit lost");
endmodule
bind lse_line_sense lse_props u_props (.i_sys_clk, .i_rst, .i_cmd, .i_data_svc, .i_bus_out,
  .i_bus_out_par, .i_sync_terminal_mode, .i_modem, .i_base_check, .i_store_par_check,
  .o_sense_byte, .o_sense_vld, .o_sense_field, .o_cmd_active);
`default_nettype wire

// >>> testbench/lse_chan_model.sv
// Purpose: Channel parity source for command bytes and bus-out data
// Assumes: Odd parity over byte and parity bit
// Notes:   i_bad inverts parity only when a scenario commands a bad byte
`timescale 1ns/1ps
`default_nettype none
module lse_chan_model (
  input  wire logic [7:0] i_byte,
  input  wire logic       i_bad,
  output logic            o_par
);
  assign o_par = ~(^i_byte) ^ i_bad;
endmodule
`default_nettype wire

// >>> testbench/line_sense_error_logic_test.sv
// Purpose: Self-checking bench for the line sense error logic
// Assumes: Short timeouts of 20 and 10 cycles
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module line_sense_error_logic_test;
  import lse_pkg::*;
  logic clk = 0, rst = 1, cv = 0, pbad = 0, par, dsvc = 0, cend = 0, sync = 1, bchk = 0;
  logic lvld = 0, enl = 1, sv, act, xvld = 0, crl = 0, cre = 0;
  logic [7:0] pb = 8'h5A, sb, sf, ser = 8'h00, txl = 8'h00;
  logic [31:0] ptmo = 32'h0000000C;
  lse_cmd_t cc = LSE_CMD_NOP;
  lse_modem_t modem = '1;
  lse_cmd_in_t cin;
  int errors = 0, checked = 0;
  assign cin = '{cv, cc, pb, par};
  always #5 clk = ~clk;
  lse_chan_model u_chan (.i_byte(pb), .i_bad(pbad), .o_par(par));
  lse_line_sense #(.TX_TMO_CYC(20), .RX_TMO_CYC(10)) dut (.i_sys_clk(clk), .i_rst(rst),
    .i_cmd(cin), .i_data_svc(dsvc), .i_bus_out(pb), .i_bus_out_par(par), .i_cmd_end(cend),
    .i_sync_terminal_mode(sync), .i_modem(modem), .i_prep_tmo_cyc(ptmo), .i_base_check(bchk),
    .i_store_par_check(bchk), .i_xfer_chk_vld(xvld), .i_serializer(ser),
    .i_tx_latch(txl), .i_latch_chk_vld(lvld), .i_enable_latch(enl),
    .i_call_req_latch(crl), .i_call_req_expect(cre), .o_sense_byte(sb),
    .o_sense_vld(sv), .o_sense_field(sf), .o_cmd_active(act));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go(lse_cmd_t c, logic bad);
    cc = c; pbad = bad; cv = 1;
    wt(1);
    cv = 0; pbad = 0;
  endtask
  task automatic endc;
    cend = 1;
    wt(1);
    cend = 0;
  endtask
  task automatic sense(logic [7:0] exp);
    go(LSE_CMD_SENSE, 0);
    chk({7'h00, sv}, 8'h01);
    chk(sb, exp);
  endtask
  task automatic pulse_in(ref logic s);
    s = 1;
    wt(1);
    s = 0;
  endtask
  task automatic t_tmo;
    modem.tx_oper = 0; go(LSE_CMD_WRITE, 0); wt(5);
    sense(8'h00);
    wt(25); sense(8'h40);
    endc; modem.rx_oper = 0; go(LSE_CMD_READ, 0); wt(20);
    sense(8'h40);
    endc; go(LSE_CMD_PREPARE, 0); wt(20);
    sense(8'h40);
    endc; modem = '1; go(LSE_CMD_WRITE, 0); endc;
    sense(8'h00);
    $display("t_tmo done");
  endtask
  task automatic t_modem;
    modem.power_on = 0; go(LSE_CMD_WRITE, 0); endc;
    sense(8'h40);
    modem = '1; modem.acu_attached = 0; go(LSE_CMD_DIAL, 0); endc;
    sense(8'h40);
    modem = '1;
    $display("t_modem done");
  endtask
  task automatic t_par;
    go(LSE_CMD_WRITE, 1); endc;
    sense(8'h20);
    go(LSE_CMD_WRITE, 0); pbad = 1; pulse_in(dsvc); pbad = 0; endc;
    sense(8'h20);
    $display("t_par done");
  endtask
  task automatic t_eq;
    go(LSE_CMD_WRITE, 0); go(LSE_CMD_WRITE, 0); endc;
    sense(8'h10);
    go(LSE_CMD_ENABLE, 0); enl = 0; pulse_in(lvld); enl = 1; endc;
    sense(8'h10);
    go(LSE_CMD_NOP, 0); endc; pulse_in(bchk);
    sense(8'h10);
    $display("t_eq done");
  endtask
  task automatic t_ss;
    sync = 0; go(LSE_CMD_WRITE, 0); ser = 8'h3C; txl = 8'h3D; pulse_in(xvld); endc;
    sense(8'h10);
    ser = 8'h00; txl = 8'h00; go(LSE_CMD_DISABLE, 0); pulse_in(lvld); endc;
    sense(8'h10);
    go(LSE_CMD_DIAL, 0); cre = 1; pulse_in(lvld); cre = 0; endc;
    sense(8'h10);
    sync = 1;
    $display("t_ss done");
  endtask
  task automatic wrap_up;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    wt(16);
    rst = 0;
    t_tmo; t_modem; t_par; t_eq; t_ss;
    wrap_up;
  end
  initial begin
    #20000;
    errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
